// ### rtl/isi_defs.svh
// Purpose: constants for the inductive sensor serial block
// Assumes: 8-bit registers, 7-bit addresses
// Notes: offsets are register addresses on the serial link
`ifndef ISI_DEFS_SVH
`define ISI_DEFS_SVH
// register addresses
`define ISI_A_ID 7'h00
`define ISI_A_CEIL 7'h01
`define ISI_A_FLOOR 7'h02
`define ISI_A_WDOG 7'h03
`define ISI_A_CONF 7'h04
`define ISI_A_RSV5 7'h05
`define ISI_A_THHI 7'h07
`define ISI_A_THLO 7'h09
`define ISI_A_PINSEL 7'h0a
`define ISI_A_PWR 7'h0b
`define ISI_A_STAT 7'h20
`define ISI_A_PROX 7'h22
`define ISI_A_FLO 7'h23
`define ISI_A_FMID 7'h24
`define ISI_A_FHI 7'h25
// reset values of stored registers, listed from 0x0b down to 0x01
`define ISI_RST_CFG {8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, \
   8'h01, 8'h1b, 8'h45, 8'h14, 8'h0e}
// id value is arbitrary, names no real part
`define ISI_ID_VAL 8'h5a
// field positions
`define ISI_RESP_MSB 2
`define ISI_RESP_LSB 0
`define ISI_PWR_BIT 0
`define ISI_MODE_MSB 2
// pin event select encodings
`define ISI_MODE_WAKE 3'h1
`define ISI_MODE_COMP 3'h2
`define ISI_MODE_DATA_READY_MODE 3'h4
// sensor periods per window at response code 0
`define ISI_WIN_UNIT 14'h0040
// data-ready pulse timing
`define ISI_CLK_MHZ 50
`define ISI_PULSE_NS 200
`define ISI_PULSE_CYC ((`ISI_PULSE_NS * `ISI_CLK_MHZ + 999) / 1000)
`endif

// ### rtl/isi_pkg.sv
// Purpose: types for the inductive sensor serial block
// Assumes: constants come from isi_defs.svh
// Notes: one packed struct carries all state of the top except the result buffer
package isi_pkg;
   typedef logic [11:1][7:0] isi_cfg_t;
   typedef struct packed {
      logic [2:0] cs_s;
      logic [2:0] sck_s;
      logic [1:0] sdi_s;
      logic [2:0] tb_s;
      logic [2:0] osc_s;
      logic [2:0] bit_cnt;
      logic in_cmd;
      logic is_read;
      logic [6:0] addr;
      logic [7:0] sh_in;
      logic [7:0] tx;
      logic sdo;
      logic sdo_oe;
      isi_cfg_t cfg;
      logic [7:0] prox;
      logic [23:0] fcnt;
      logic data_ready_mode_n;
      logic cmp;
      logic wake;
      logic data_ready_mode_int;
      logic [3:0] pulse_cnt;
      logic int_n;
      logic win_run;
      logic [13:0] win_per;
      logic [23:0] win_tb;
   } isi_state_t;
endpackage

// ### rtl/isi_spi_interrupt_out_n.sv
// Purpose: serial register access, interrupt pin and counter
// Assumes: pins are asynchronous to core_clk and synchronised
// Notes:
// Notes on behaviour
// R1: access opens with direction bit plus address
// R2: direction bit zero writes, one reads
// R3: each chip select assertion restarts the access
// R4: data out on falling, sampled on rising
// R5: write commits on sixteenth rising clock
// R6: early chip select release writes nothing
// R7: master keeps select through sixteenth clock
// R8: longer select auto-increments the address
// R9: master holds select eight times one-plus-N
// R10: one byte per eight clocks after command
// R11: read from 0x22 streams proximity then count
// R12: device only answers, never starts transfers
// R13: standby after reset, convert only when active
// R14: comparator sets above high, clears below low
// R15: wake-up holds until wake mode is left
// R16: data-ready asserts on data, clears on read
// R17: new data during access gives a pulse
// R18: new data valid only with select high
// R19: timebase clock times the frequency counter
// R20: window length follows the response-time field
// R21: proximity result stored at 0x22
// R22: below floor the result saturates full scale
// R23: 0x01 to 0x05 locked while active
// R24: between thresholds the comparator holds
`timescale 1ns/1ps
`include "isi_defs.svh"

// ------------------------------------------------------------
// result buffer between converter and result registers
// ------------------------------------------------------------
module isi_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   // handshake terms and flags
   assign in_ready = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid = cnt_reg != '0;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_reg];

   // pointers and occupancy
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
            wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
         if (pop)
            rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
         if (push && !pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop && !push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // storage, no reset needed
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_reg] <= in_data;
   end
endmodule

// ------------------------------------------------------------
// top: serial slave, result registers, interrupt pin
// ------------------------------------------------------------
module isi_spi_interrupt_out_n (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // serial link pins
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe,
   // interrupt pin
   output logic interrupt_out_n,
   // counter clocks
   input wire logic timebase_clock,
   input wire logic sensor_osc,
   // analog front end result, core_clk domain
   input wire logic [7:0] prox_code,
   input wire logic prox_below_floor
);
   isi_pkg::isi_state_t s_reg;
   isi_pkg::isi_state_t s_next;
   logic push_valid;
   logic push_ready;
   logic [31:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [31:0] pop_data;

   // read mux over the register map
   function automatic logic [7:0] rd_byte(
      input isi_pkg::isi_state_t st,
      input logic [6:0] a
   );
      logic [7:0] v;
      v = 8'h00;
      if (a == `ISI_A_ID)
         v = `ISI_ID_VAL; // arbitrary neutral value
      else if (a <= `ISI_A_PWR)
         v = st.cfg[a[3:0]];
      else if (a == `ISI_A_STAT)
         v = {1'b0, st.data_ready_mode_n, st.wake, st.cmp, 4'h0};
      else if (a == `ISI_A_PROX)
         v = st.prox; // [R21] [R11]
      else if (a == `ISI_A_FLO)
         v = st.fcnt[7:0]; // [R19]
      else if (a == `ISI_A_FMID)
         v = st.fcnt[15:8];
      else if (a == `ISI_A_FHI)
         v = st.fcnt[23:16];
      return v;
   endfunction

   // stored registers that a write may change
   function automatic logic writable(
      input logic [6:0] a,
      input logic active
   );
      logic ok;
      ok = (a >= `ISI_A_CEIL) && (a <= `ISI_A_PWR);
      if (a == `ISI_A_RSV5)
         ok = 1'b0;
      if (active && a <= `ISI_A_RSV5)
         ok = 1'b0; // [R23]
      return ok;
   endfunction

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      logic cs_act;
      logic sck_rise;
      logic sck_fall;
      logic tb_rise;
      logic osc_rise;
      logic active;
      logic [7:0] byte_in;
      logic [13:0] target;
      logic [2:0] mode;
      logic [7:0] clip;
      logic irq;
      cs_act = 1'b0;
      sck_rise = 1'b0;
      sck_fall = 1'b0;
      tb_rise = 1'b0;
      osc_rise = 1'b0;
      active = 1'b0;
      byte_in = 8'h00;
      target = 14'h0000;
      mode = 3'h0;
      clip = 8'h00;
      irq = 1'b0;
      s_next = s_reg;
      // two-stage synchronisers, plus an edge stage on all but sdi
      s_next.cs_s = {s_reg.cs_s[1:0], chip_select_n};
      s_next.sck_s = {s_reg.sck_s[1:0], sclk};
      s_next.sdi_s = {s_reg.sdi_s[0], sdi};
      s_next.tb_s = {s_reg.tb_s[1:0], timebase_clock};
      s_next.osc_s = {s_reg.osc_s[1:0], sensor_osc};
      cs_act = ~s_reg.cs_s[1];
      sck_rise = s_reg.sck_s[1] & ~s_reg.sck_s[2];
      sck_fall = ~s_reg.sck_s[1] & s_reg.sck_s[2];
      tb_rise = s_reg.tb_s[1] & ~s_reg.tb_s[2];
      osc_rise = s_reg.osc_s[1] & ~s_reg.osc_s[2];
      active = s_reg.cfg[`ISI_A_PWR][`ISI_PWR_BIT];
      mode = s_reg.cfg[`ISI_A_PINSEL][`ISI_MODE_MSB:0];
      // serial slave, driven only by the master's select
      s_next.sdo_oe = cs_act; // [R12]
      if (!cs_act)
      begin
         // idle select: next assertion starts clean
         s_next.bit_cnt = 3'h0; // [R3]
         s_next.in_cmd = 1'b1;
         s_next.is_read = 1'b0;
         s_next.tx = 8'h00;
         s_next.sdo = 1'b0;
      end
      else
      begin
         if (sck_fall)
         begin
            // shift out on the falling edge
            s_next.sdo = s_reg.tx[7]; // [R4]
            s_next.tx = {s_reg.tx[6:0], 1'b0};
         end
         if (sck_rise)
         begin
            // sample on the rising edge
            byte_in = {s_reg.sh_in[6:0], s_reg.sdi_s[1]}; // [R4]
            s_next.sh_in = byte_in;
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1; // [R10]
            if (s_reg.bit_cnt == 3'h7)
            begin
               if (s_reg.in_cmd)
               begin
                  // command byte: direction then address
                  s_next.in_cmd = 1'b0; // [R1]
                  s_next.is_read = byte_in[7]; // [R2]
                  s_next.addr = byte_in[6:0];
                  if (byte_in[7])
                     s_next.tx = rd_byte(s_reg, byte_in[6:0]);
                  if (byte_in[7] && byte_in[6:0] == `ISI_A_PROX)
                  begin
                     // read command on the result registered
                     s_next.data_ready_mode_int = 1'b0; // [R16]
                     s_next.data_ready_mode_n = 1'b1;
                  end
               end
               else
               begin
                  // data byte complete; partial bytes never land
                  if (!s_reg.is_read && writable(s_reg.addr, active))
                     s_next.cfg[s_reg.addr[3:0]] = byte_in; // [R5] [R6]
                  s_next.addr = s_reg.addr + 7'h01; // [R8]
                  if (s_reg.is_read)
                     s_next.tx = rd_byte(s_reg, s_reg.addr + 7'h01); // [R11]
               end
            end
         end
      end
      // frequency window: sensor periods timed by the timebase
      target = `ISI_WIN_UNIT << s_reg.cfg[`ISI_A_CONF][`ISI_RESP_MSB:
         `ISI_RESP_LSB]; // [R20]
      clip = prox_below_floor ? 8'hff : prox_code; // [R22]
      push_valid = s_reg.win_run & osc_rise &
         (s_reg.win_per + 14'h0001 == target);
      push_data = {clip, s_reg.win_tb};
      if (!active)
      begin
         // standby: no conversions
         s_next.win_run = 1'b0; // [R13]
         s_next.win_per = 14'h0000;
         s_next.win_tb = 24'h000000;
      end
      else if (!s_reg.win_run)
      begin
         // start only when the buffer can take the result
         if (push_ready)
         begin
            s_next.win_run = 1'b1;
            s_next.win_per = 14'h0000;
            s_next.win_tb = 24'h000000;
         end
      end
      else
      begin
         if (tb_rise)
            s_next.win_tb = s_reg.win_tb + 24'h000001; // [R19]
         if (osc_rise)
            s_next.win_per = s_reg.win_per + 14'h0001;
         if (push_valid)
            s_next.win_run = 1'b0;
      end
      // result registers: not updated under a data-phase read
      pop_ready = ~(cs_act & s_reg.is_read & ~s_reg.in_cmd);
      if (s_reg.pulse_cnt != 4'h0)
         s_next.pulse_cnt = s_reg.pulse_cnt - 4'h1;
      if (pop_valid && pop_ready)
      begin
         s_next.prox = pop_data[31:24]; // [R21]
         s_next.fcnt = pop_data[23:0];
         s_next.data_ready_mode_n = 1'b0;
         if (!cs_act)
            s_next.data_ready_mode_int = 1'b1; // [R18] [R16]
         else
            s_next.pulse_cnt = 4'(`ISI_PULSE_CYC); // [R17]
      end
      // threshold comparator with hysteresis
      if (s_reg.prox > s_reg.cfg[`ISI_A_THHI])
         s_next.cmp = 1'b1; // [R14]
      else if (s_reg.prox < s_reg.cfg[`ISI_A_THLO])
         s_next.cmp = 1'b0; // [R14]
      else
         s_next.cmp = s_reg.cmp; // [R24]
      // wake latch, released only by leaving wake mode
      if (mode != `ISI_MODE_WAKE)
         s_next.wake = 1'b0; // [R15]
      else if (s_reg.prox > s_reg.cfg[`ISI_A_THHI])
         s_next.wake = 1'b1; // [R15]
      // pin event select
      unique case (mode)
         `ISI_MODE_COMP: irq = s_reg.cmp;
         `ISI_MODE_WAKE: irq = s_reg.wake;
         `ISI_MODE_DATA_READY_MODE: irq = s_reg.data_ready_mode_int |
            (s_reg.pulse_cnt != 4'h0);
         default: irq = 1'b0;
      endcase
      s_next.int_n = ~irq;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_reg <= '0;
         s_reg.cs_s <= 3'h7;
         s_reg.in_cmd <= 1'b1;
         s_reg.cfg <= `ISI_RST_CFG; // [R13]
         s_reg.data_ready_mode_n <= 1'b1;
         s_reg.int_n <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // result buffer
   isi_fifo #(
      .WIDTH(32),
      .DEPTH(8)
   ) u_fifo (
      .clk(core_clk),
      .resetn(resetn),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(pop_valid),
      .out_ready(pop_ready),
      .out_data(pop_data)
   );

   // outputs straight from flops
   assign sdo = s_reg.sdo;
   assign sdo_oe = s_reg.sdo_oe;
   assign interrupt_out_n = s_reg.int_n;
endmodule

// ### testbench/isi_spi_interrupt_out_n_props.sv
// Purpose: port checks for the serial block
// Assumes: sclk half period of four core clocks
// Notes: bound to every top instance
`timescale 1ns/1ps
module isi_spi_interrupt_out_n_props (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // pins
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic interrupt_out_n
);
   logic sclk_q;
   logic [3:0] since_fall;
   logic [3:0] rises;
   // cycles since sclk fell, sclk rises in the frame
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sclk_q <= 1'b0;
         since_fall <= 4'hf;
         rises <= 4'h0;
      end
      else
      begin
         sclk_q <= sclk;
         if (sclk_q && !sclk)
            since_fall <= 4'h0;
         else if (since_fall != 4'hf)
            since_fall <= since_fall + 4'h1;
         if (chip_select_n)
            rises <= 4'h0;
         else if (!sclk_q && sclk && rises != 4'hf)
            rises <= rises + 4'h1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence sel_idle;
      chip_select_n [*5];
   endsequence
   sequence sel_busy;
      !chip_select_n [*5];
   endsequence
   sequence bit_edge;
      $changed(sdo) && !chip_select_n && !$past(chip_select_n);
   endsequence
   // -----------------------------------------------------------
   // pin relations
   // -----------------------------------------------------------
   chk_idle_quiet: assert property (sel_idle |-> !sdo_oe && !sdo)
      else $error("sdo driven while not selected");
   chk_oe_release: assert property (
      $rose(chip_select_n) |-> ##[1:5] !sdo_oe)
      else $error("sdo_oe held after select release");
   chk_oe_needs_sel: assert property (
      $rose(sdo_oe) |-> !chip_select_n && !$past(chip_select_n, 2))
      else $error("sdo_oe rose without select");
   chk_oe_follows: assert property (sel_busy |-> sdo_oe)
      else $error("sdo_oe low while selected");
   chk_sdo_after_fall: assert property (
      bit_edge |-> since_fall <= 4'h4)
      else $error("sdo changed away from an sclk fall");
   chk_sdo_after_cmd: assert property (bit_edge |-> rises >= 4'h8)
      else $error("sdo changed inside command byte");
   chk_bit_spacing: assert property (
      bit_edge |=> $stable(sdo) [*5])
      else $error("sdo changed twice within one bit");
   chk_reset_quiet: assert property (
      $rose(resetn) |-> interrupt_out_n && !sdo_oe)
      else $error("outputs active after reset");
endmodule
bind isi_spi_interrupt_out_n isi_spi_interrupt_out_n_props isi_spi_interrupt_out_n_props_i (.core_clk,
   .resetn, .chip_select_n, .sclk, .sdo, .sdo_oe, .interrupt_out_n);

// ### testbench/isi_spi_master.sv
// Purpose: serial master standing in for the host controller
// Assumes: sclk period of eight core clocks
// Notes: sclk idles low, sdi shows the inverse bit when idle
`timescale 1ns/1ps
module isi_spi_master (
   // clock
   input wire logic clk,
   // serial link
   output logic chip_select_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   // idle link
   initial
   begin
      chip_select_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // one framed access of n clocks, msb first
   task automatic access(input logic [39:0] bits, input int n,
      output logic [31:0] rd);
      rd = 32'h0;
      @(posedge clk);
      chip_select_n <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         sdi <= bits[39-i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         if (i >= 8)
            rd = {rd[30:0], sdo};
         sclk <= 1'b0;
      end
      repeat (8) @(posedge clk);
      chip_select_n <= 1'b1;
      sdi <= ~sdi;
      repeat (4) @(posedge clk);
   endtask
endmodule

// ### testbench/isi_spi_interrupt_out_n_tb.sv
// Purpose: register, counter and pin checks of the serial block
// Assumes: sensor at eight core clocks, time base at four
// Notes: response code 0 gives a 64-period window
`timescale 1ns/1ps
module isi_spi_interrupt_out_n_tb;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic chip_select_n, sclk, sdi, sdo, sdo_oe, interrupt_out_n;
   logic timebase_clock = 1'b0;
   logic sensor_osc = 1'b0;
   logic [7:0] prox_code = 8'h00;
   logic prox_below_floor = 1'b0;
   logic [31:0] rd;
   logic [23:0] fc;
   logic [2:0] cyc = 3'h0;
   int errors = 0;
   int checked = 0;
   // reset values of 0x00..0x0b
   logic [7:0] rst_val [12] = '{8'h5a, 8'h0e, 8'h14, 8'h45, 8'h1b,
      8'h01, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
   // pin mode, proximity, spare, expected pin level
   logic [15:0] steps [6] = '{16'h2900, 16'h2600, 16'h2301,
      16'h1900, 16'h1300, 16'h0301};
   always #10 core_clk = ~core_clk;
   // sensor and time base oscillators
   always @(posedge core_clk)
   begin
      cyc <= cyc + 3'h1;
      sensor_osc <= cyc[2];
      timebase_clock <= cyc[1];
   end
   isi_spi_interrupt_out_n isi_spi_interrupt_out_n_i (.core_clk, .resetn, .chip_select_n,
      .sclk, .sdi, .sdo, .sdo_oe, .interrupt_out_n, .timebase_clock,
      .sensor_osc, .prox_code, .prox_below_floor);
   isi_spi_master isi_spi_master_i (.clk(core_clk), .chip_select_n,
      .sclk, .sdi, .sdo);
   // -----------------------------------------------------------
   // access and compare tasks
   // -----------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      isi_spi_master_i.access({1'b0, a, d, 24'h0}, 16, rd);
   endtask
   task automatic rdb(input logic [6:0] a, input int n);
      isi_spi_master_i.access({1'b1, a, 32'h0}, 8 + 8 * n, rd);
   endtask
   task automatic give_verdict;
      if (errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (60000) @(posedge core_clk);
      errors++;
      give_verdict;
   end
   // main sequence
   initial
   begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("oe", sdo_oe, 1'b0);
      foreach (rst_val[i])
      begin
         rdb(7'(i), 1);
         chk("reset", rd[7:0], rst_val[i]);
      end
      // thresholds through one burst write, read back as a burst
      isi_spi_master_i.access({8'h07, 32'h80_00_40_00}, 32, rd);
      rdb(7'h07, 3);
      chk("burst", rd[23:0], 24'h800040);
      // select dropped one clock early stores nothing
      isi_spi_master_i.access({8'h09, 8'h33, 24'h0}, 15, rd);
      rdb(7'h09, 1);
      chk("abort", rd[7:0], 8'h40);
      // response code 0, then active mode locks 0x04
      wr(7'h04, 8'h18);
      wr(7'h0b, 8'h01);
      wr(7'h04, 8'h1c);
      rdb(7'h04, 1);
      chk("locked", rd[7:0], 8'h18);
      foreach (steps[i])
      begin
         wr(7'h0a, {5'h00, steps[i][14:12]});
         prox_code <= steps[i][11:4];
         repeat (1600) @(posedge core_clk);
         chk("pin", interrupt_out_n, steps[i][0]);
      end
      // resistance below the floor clips the result
      prox_below_floor <= 1'b1;
      repeat (1600) @(posedge core_clk);
      rdb(7'h22, 1);
      chk("clip", rd[7:0], 8'hff);
      // data-ready hold, then streamed result read in standby
      prox_below_floor <= 1'b0;
      prox_code <= 8'h55;
      wr(7'h0a, 8'h04);
      repeat (1600) @(posedge core_clk);
      wr(7'h0b, 8'h00);
      repeat (1600) @(posedge core_clk);
      chk("ready", interrupt_out_n, 1'b0);
      rdb(7'h22, 4);
      chk("prox", rd[31:24], 8'h55);
      fc = {rd[7:0], rd[15:8], rd[23:16]};
      // 64 sensor periods hold 128 time base rises, one either way
      chk("fcnt", fc >= 24'd127 && fc <= 24'd129, 1'b1);
      chk("cleared", interrupt_out_n, 1'b1);
      repeat (1000) @(posedge core_clk);
      chk("standby", interrupt_out_n, 1'b1);
      give_verdict;
   end
endmodule
